// ==== verilog/tcs_cfg.svh ====
// constants for the transceiver control and status block
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH

`define TCS_CLK_NS        40
`define TCS_ADDR_ID       7'h50
`define TCS_ADDR_DIAG     7'h51
`define TCS_STATUS_BYTE   8'h6e
`define TCS_BIT_SOFT_DIS  6
`define TCS_BIT_FAULT     2
`define TCS_BIT_RX_LOST   1
`define TCS_BIT_DATA_RDY  0
`define TCS_PAGE_BITS     3
`define TCS_T_RESET_NS    10000
`define TCS_T_INIT_MS     300
`define TCS_T_DATA_MS     1000
`define TCS_T_SERIAL_MS   300
`define TCS_T_WRITE_MS    10
`define TCS_RESET_CYC     ((`TCS_T_RESET_NS + `TCS_CLK_NS - 1) / `TCS_CLK_NS)
`define TCS_INIT_CYC      (`TCS_T_INIT_MS * 1000000 / `TCS_CLK_NS)
`define TCS_DATA_CYC      (`TCS_T_DATA_MS * 1000000 / `TCS_CLK_NS)
`define TCS_SERIAL_CYC    (`TCS_T_SERIAL_MS * 1000000 / `TCS_CLK_NS)
`define TCS_WRITE_CYC     (`TCS_T_WRITE_MS * 1000000 / `TCS_CLK_NS)

`endif

// ==== verilog/tcs_pkg.sv ====
// types for the transceiver control and status block
`default_nettype none
package tcs_pkg;
  typedef enum logic [6:0] {
    TCS_IDLE  = 7'h01,
    TCS_ADDR  = 7'h02,
    TCS_ACK_A = 7'h04,
    TCS_WR    = 7'h08,
    TCS_ACK_W = 7'h10,
    TCS_RD    = 7'h20,
    TCS_ACK_R = 7'h40
  } tcs_state_t;
endpackage
`default_nettype wire

// ==== verilog/tcs_ctrl.sv ====
// transceiver control, status and two-wire slave
`timescale 1ns/10ps
`default_nettype none
`include "tcs_cfg.svh"

module tcs_ctrl #(
  parameter int unsigned INIT_CYC   = `TCS_INIT_CYC,
  parameter int unsigned DATA_CYC   = `TCS_DATA_CYC,
  parameter int unsigned SERIAL_CYC = `TCS_SERIAL_CYC
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic laser_disable_in,
  input  wire logic laser_fault_in,
  input  wire logic signal_detect_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output var  logic sda_out,
  output var  logic sda_oe_out,
  output var  logic laser_on_out,
  output var  logic tx_fault_out,
  output var  logic receive_signal_lost_out
);

  localparam int unsigned RESET_CYC = `TCS_RESET_CYC;

  // synchronisers start at idle levels so no false bus edge follows reset
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic [4:0] prev_r;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sync1_r <= 5'h18;
      sync2_r <= 5'h18;
      prev_r  <= 5'h18;
    end
    else
    begin
      sync1_r <= {scl_in, sda_in, signal_detect_in, laser_fault_in,
                  laser_disable_in};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  wire hw_dis   = sync2_r[0];
  wire fault_in = sync2_r[1];
  wire sig_ok   = sync2_r[2];
  wire sda_q    = sync2_r[3];
  wire scl_q    = sync2_r[4];
  wire sda_p    = prev_r[3];
  wire scl_p    = prev_r[4];

  wire scl_rise = scl_q & ~scl_p;
  wire scl_fall = ~scl_q & scl_p;
  wire bus_start = scl_q & scl_p & sda_p & ~sda_q;
  wire bus_stop  = scl_q & scl_p & ~sda_p & sda_q;
  wire dis_fall  = ~hw_dis & prev_r[0];

  // power-up timers
  logic [31:0] pwr_cnt_r;
  logic [31:0] init_cnt_r;
  logic [31:0] hold_cnt_r;
  logic        fault_r;
  logic        soft_dis_r;
  logic        soft_pend_r;
  logic        soft_val_r;

  wire serial_rdy = pwr_cnt_r >= SERIAL_CYC;
  wire data_rdy   = pwr_cnt_r >= DATA_CYC;
  wire init_done  = init_cnt_r >= INIT_CYC;
  wire held_long  = hold_cnt_r >= RESET_CYC;
  wire fault_clr  = dis_fall & held_long & fault_r;
  wire laser_nxt  = ~hw_dis & ~soft_dis_r & ~fault_r & init_done;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      pwr_cnt_r <= 32'h0;
    else if (!data_rdy)
      pwr_cnt_r <= pwr_cnt_r + 32'h1;
  end

  // a cleared fault restarts initialisation like power-on
  always_ff @(posedge clk_in)
  begin
    if (rst_in || fault_clr)
      init_cnt_r <= 32'h0;
    else if (!init_done)
      init_cnt_r <= init_cnt_r + 32'h1;
  end

  // saturating so a long hold cannot wrap back below the limit
  always_ff @(posedge clk_in)
  begin
    if (rst_in || !hw_dis)
      hold_cnt_r <= 32'h0;
    else if (!held_long)
      hold_cnt_r <= hold_cnt_r + 32'h1;
  end

  // fault only counts while the laser is really driven
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      fault_r <= 1'b0;
    else if (fault_in && laser_on_out)
      fault_r <= 1'b1;
    else if (fault_clr)
      fault_r <= 1'b0;
  end

  // soft disable takes effect at the stop that ends the write
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      soft_dis_r <= 1'b0;
    else if (bus_stop && soft_pend_r)
      soft_dis_r <= soft_val_r;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      laser_on_out            <= 1'b0;
      tx_fault_out            <= 1'b0;
      receive_signal_lost_out <= 1'b1;
      sda_out                 <= 1'b0;
    end
    else
    begin
      laser_on_out            <= laser_nxt;
      tx_fault_out            <= fault_r;
      receive_signal_lost_out <= ~sig_ok;
      sda_out                 <= 1'b0;
    end
  end

  // two-wire slave: both spaces share one array, space is top address bit
  tcs_pkg::tcs_state_t st_r;
  logic [7:0] shreg_r;
  logic [7:0] tx_r;
  logic [7:0] ptr_r;
  logic [3:0] bitcnt_r;
  logic       rnw_r;
  logic       diag_r;
  logic       first_r;
  logic       nack_r;
  logic [7:0] mem [0:511];

  wire [6:0] dev_addr = shreg_r[7:1];
  wire addr_hit = serial_rdy &&
                  (dev_addr == `TCS_ADDR_ID || dev_addr == `TCS_ADDR_DIAG);
  wire byte_full = bitcnt_r == 4'h8;
  wire at_status = diag_r && ptr_r == `TCS_STATUS_BYTE;

  wire [7:0] status_byte;
  assign status_byte = {1'b0, soft_dis_r, 3'h0, fault_r, ~sig_ok,
                        data_rdy};
  wire [7:0] rd_byte = at_status ? status_byte : mem[{diag_r, ptr_r}];

  // writes wrap inside an eight-byte page
  wire [7:0] ptr_wr_nxt = {ptr_r[7:`TCS_PAGE_BITS],
                           ptr_r[`TCS_PAGE_BITS-1:0] + 3'h1};
  wire data_wr = (st_r == tcs_pkg::TCS_WR) && scl_fall && byte_full &&
                 !first_r;

  // array has no reset: contents are loaded by the host or production
  always_ff @(posedge clk_in)
  begin
    if (data_wr && !at_status)
      mem[{diag_r, ptr_r}] <= shreg_r;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      soft_pend_r <= 1'b0;
      soft_val_r  <= 1'b0;
    end
    else if (bus_start || bus_stop)
      soft_pend_r <= 1'b0;
    else if (data_wr && at_status)
    begin
      soft_pend_r <= 1'b1;
      soft_val_r  <= shreg_r[`TCS_BIT_SOFT_DIS];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in || bus_stop)
    begin
      st_r       <= tcs_pkg::TCS_IDLE;
      sda_oe_out <= 1'b0;
      bitcnt_r   <= 4'h0;
      if (rst_in)
      begin
        shreg_r <= 8'h00;
        tx_r    <= 8'h00;
        ptr_r   <= 8'h00;
        rnw_r   <= 1'b0;
        diag_r  <= 1'b0;
        first_r <= 1'b0;
        nack_r  <= 1'b0;
      end
    end
    else if (bus_start)
    begin
      st_r       <= tcs_pkg::TCS_ADDR;
      sda_oe_out <= 1'b0;
      bitcnt_r   <= 4'h0;
    end
    else
    begin
      if (scl_rise)
      begin
        if (st_r == tcs_pkg::TCS_ADDR || st_r == tcs_pkg::TCS_WR)
        begin
          shreg_r  <= {shreg_r[6:0], sda_q};
          bitcnt_r <= bitcnt_r + 4'h1;
        end
        if (st_r == tcs_pkg::TCS_ACK_R)
          nack_r <= sda_q;
      end
      if (scl_fall)
      begin
        case (st_r)
          tcs_pkg::TCS_ADDR:
          begin
            if (byte_full)
            begin
              // before the ready time the module stays silent
              if (addr_hit)
              begin
                st_r       <= tcs_pkg::TCS_ACK_A;
                sda_oe_out <= 1'b1;
                rnw_r      <= shreg_r[0];
                diag_r     <= shreg_r[1];
              end
              else
                st_r <= tcs_pkg::TCS_IDLE;
            end
          end
          tcs_pkg::TCS_ACK_A:
          begin
            bitcnt_r <= 4'h0;
            if (rnw_r)
            begin
              st_r       <= tcs_pkg::TCS_RD;
              tx_r       <= rd_byte;
              sda_oe_out <= ~rd_byte[7];
            end
            else
            begin
              st_r       <= tcs_pkg::TCS_WR;
              sda_oe_out <= 1'b0;
              first_r    <= 1'b1;
            end
          end
          tcs_pkg::TCS_WR:
          begin
            if (byte_full)
            begin
              st_r       <= tcs_pkg::TCS_ACK_W;
              sda_oe_out <= 1'b1;
              first_r    <= 1'b0;
              if (first_r)
                ptr_r <= shreg_r;
              else
                ptr_r <= ptr_wr_nxt;
            end
          end
          tcs_pkg::TCS_ACK_W:
          begin
            st_r       <= tcs_pkg::TCS_WR;
            sda_oe_out <= 1'b0;
            bitcnt_r   <= 4'h0;
          end
          tcs_pkg::TCS_RD:
          begin
            if (bitcnt_r == 4'h7)
            begin
              st_r       <= tcs_pkg::TCS_ACK_R;
              sda_oe_out <= 1'b0;
              ptr_r      <= ptr_r + 8'h01;
            end
            else
            begin
              tx_r       <= {tx_r[6:0], 1'b0};
              sda_oe_out <= ~tx_r[6];
              bitcnt_r   <= bitcnt_r + 4'h1;
            end
          end
          tcs_pkg::TCS_ACK_R:
          begin
            bitcnt_r <= 4'h0;
            if (nack_r)
            begin
              st_r       <= tcs_pkg::TCS_IDLE;
              sda_oe_out <= 1'b0;
            end
            else
            begin
              st_r       <= tcs_pkg::TCS_RD;
              tx_r       <= rd_byte;
              sda_oe_out <= ~rd_byte[7];
            end
          end
          default:
          begin
            st_r       <= tcs_pkg::TCS_IDLE;
            sda_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ==== verification/tcs_host.sv ====
// two-wire host model for the bench
`timescale 1ns/10ps
`default_nettype none
module tcs_host (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output var  logic scl_out,
  output var  logic sda_out
);
  // released lines float high; scl stands high between frames
  initial {scl_out, sda_out} = 2'h3;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // 320 ns per bit runs well above the fast-mode rate
  task automatic bit_io(input logic d, output logic q);
    scl_out <= 1'b0;
    cyc(2);
    sda_out <= d;
    cyc(2);
    scl_out <= 1'b1;
    cyc(4);
    q = sda_in;
  endtask
  // lvl 0 gives a start, lvl 1 a stop
  task automatic cond(input logic lvl);
    logic q;
    bit_io(~lvl, q);
    sda_out <= lvl;
    cyc(4);
  endtask
  task automatic byte_io(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--)
      bit_io(d[i], q[i]);
  endtask
  // eight data bytes in one write, lowest byte of wd first
  task automatic burst(input logic [6:0] dev, input logic [7:0] ptr,
    input logic [63:0] wd, output logic nak);
    logic [8:0] q;
    cond(1'b0);
    byte_io({dev, 2'b01}, q);
    nak = q[0];
    byte_io({ptr, 1'b1}, q);
    nak = nak | q[0];
    for (int k = 0; k < 8; k++)
    begin
      byte_io({wd[8*k +: 8], 1'b1}, q);
      nak = nak | q[0];
    end
    cond(1'b1);
  endtask
  task automatic xact(input logic [6:0] dev, input logic [7:0] ptr,
    input logic rd, input logic [7:0] wd, output logic [7:0] rq,
    output logic nak);
    logic [8:0] a;
    logic [8:0] b;
    logic [8:0] q;
    cond(1'b0);
    byte_io({dev, 2'b01}, a);
    byte_io({ptr, 1'b1}, b);
    if (rd)
    begin
      cond(1'b0);
      byte_io({dev, 2'b11}, q);
      b[0] = b[0] | q[0];
      byte_io(9'h1ff, q);
    end
    else
      byte_io({wd, 1'b1}, q);
    cond(1'b1);
    rq = q[8:1];
    nak = a[0] | b[0] | (q[0] & !rd);
  endtask
endmodule
`default_nettype wire

// ==== verification/tcs_ctrl_props.sv ====
// port assertions for the control and status block
`timescale 1ns/10ps
`default_nettype none
module tcs_ctrl_props #(
  parameter int unsigned INIT_CYC   = 200,
  parameter int unsigned SERIAL_CYC = 100
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic laser_disable_in,
  input wire logic laser_fault_in,
  input wire logic signal_detect_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic laser_on_out,
  input wire logic tx_fault_out,
  input wire logic receive_signal_lost_out
);
  logic [31:0] up_r;
  logic [15:0] hi_r;
  logic [15:0] run_r;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // run_r keeps the length of the latest disable-pin high run
  always_ff @(posedge clk_in)
  begin
    up_r  <= rst_in ? 32'h0 : up_r + 32'h1;
    hi_r  <= laser_disable_in ? hi_r + 16'h1 : 16'h0;
    run_r <= laser_disable_in ? hi_r + 16'h1 : run_r;
  end
  dis_off_a: assert property (
    laser_disable_in [*6] |-> !laser_on_out) else $error("laser on");
  fault_set_a: assert property (
    ($rose(laser_fault_in) && laser_on_out) ##1
    (laser_fault_in && laser_on_out) [*2] |-> ##[0:4] tx_fault_out)
    else $error("fault not latched");
  los_set_a: assert property (
    !signal_detect_in [*6] |-> receive_signal_lost_out)
    else $error("loss not shown");
  los_clr_a: assert property (
    signal_detect_in [*6] |-> !receive_signal_lost_out)
    else $error("loss stuck");
  fault_clr_a: assert property (
    $fell(tx_fault_out) |-> run_r >= 16'h00fa) else $error("early clear");
  init_min_a: assert property (
    laser_on_out |-> up_r >= INIT_CYC) else $error("laser on early");
  init_max_a: assert property (
    (!laser_disable_in && !tx_fault_out) [*6] ##0 (up_r == INIT_CYC + 8)
    |-> laser_on_out) else $error("laser late");
  bus_wait_a: assert property (
    up_r < SERIAL_CYC |-> !sda_oe_out) else $error("early ack");
  sda_hold_a: assert property (
    $changed(sda_oe_out) |-> !$past(scl_in)) else $error("sda moved");
endmodule
bind tcs_ctrl tcs_ctrl_props #(
  .INIT_CYC   (INIT_CYC),
  .SERIAL_CYC (SERIAL_CYC)
) u_props (
  .clk_in(clk_in), .rst_in(rst_in), .laser_disable_in(laser_disable_in),
  .laser_fault_in(laser_fault_in), .signal_detect_in(signal_detect_in),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .laser_on_out(laser_on_out),
  .tx_fault_out(tx_fault_out),
  .receive_signal_lost_out(receive_signal_lost_out));
`default_nettype wire

// ==== verification/test_transceiver_control_status.sv ====
// self-checking bench for the control and status block
`timescale 1ns/10ps
`default_nettype none
module test_transceiver_control_status;
  localparam int INIT = 200;
  logic        clk_in, rst_in, dis, flt, det, scl, hsda, sda_o, sda_oe;
  logic        laser, fault, lost, nak, soft_m, flt_m, lost_m;
  logic [7:0]  d;
  logic [63:0] w;
  logic [31:0] seed;
  logic [7:0]  q_m [$];
  int          fails, compares;
  wire logic   sda_w = hsda & (sda_oe ? sda_o : 1'b1);
  tcs_ctrl #(.INIT_CYC(INIT), .DATA_CYC(400), .SERIAL_CYC(100)) uut (
    .clk_in(clk_in), .rst_in(rst_in), .laser_disable_in(dis),
    .laser_fault_in(flt), .signal_detect_in(det), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .laser_on_out(laser), .tx_fault_out(fault),
    .receive_signal_lost_out(lost));
  tcs_host host (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl),
    .sda_out(hsda));
  always #20 clk_in = ~clk_in;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic diag(input logic rd, input logic [7:0] wd);
    host.xact(7'h51, 8'h6e, rd, wd, d, nak);
    if (rd)
      chk(d, {1'b0, soft_m, 3'h0, flt_m, lost_m, 1'b1});
  endtask
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    cyc(40000);
    fails++;
    tally_and_finish();
  end
  initial
  begin
    clk_in = 1'b0;
    rst_in = 1'b1;
    {dis, flt, det, soft_m, flt_m, lost_m} = 6'h08;
    seed = 32'h0000_7824;
    fails = 0;
    compares = 0;
    cyc(12);
    rst_in <= 1'b0;
    // too early: at least one byte of the write must go unanswered
    host.xact(7'h51, 8'h6e, 1'b0, 8'h40, d, nak);
    chk({7'h0, nak}, 8'h01);
    cyc(420);
    chk({7'h0, laser}, 8'h01);
    diag(1'b1, 8'h00);
    $display("test power-up done");
    diag(1'b0, 8'h40);
    soft_m = 1'b1;
    cyc(6);
    chk({7'h0, laser}, 8'h00);
    diag(1'b1, 8'h00);
    diag(1'b0, 8'h00);
    soft_m = 1'b0;
    cyc(6);
    chk({7'h0, laser}, 8'h01);
    $display("test soft disable done");
    dis <= 1'b1;
    cyc(8);
    chk({7'h0, laser}, 8'h00);
    dis <= 1'b0;
    det <= 1'b0;
    lost_m = 1'b1;
    cyc(8);
    chk({6'h0, lost, laser}, 8'h03);
    diag(1'b1, 8'h00);
    det <= 1'b1;
    lost_m = 1'b0;
    cyc(8);
    chk({7'h0, lost}, 8'h00);
    diag(1'b1, 8'h00);
    $display("test pins done");
    flt <= 1'b1;
    flt_m = 1'b1;
    cyc(8);
    chk({6'h0, fault, laser}, 8'h02);
    diag(1'b1, 8'h00);
    flt <= 1'b0;
    dis <= 1'b1;
    cyc(100);
    dis <= 1'b0;
    cyc(8);
    chk({7'h0, fault}, 8'h01);
    dis <= 1'b1;
    cyc(260);
    dis <= 1'b0;
    flt_m = 1'b0;
    cyc(8);
    chk({6'h0, fault, laser}, 8'h00);
    cyc(INIT + 8);
    chk({7'h0, laser}, 8'h01);
    diag(1'b1, 8'h00);
    $display("test fault done");
    for (int i = 0; i < 4; i++)
    begin
      q_m.push_back(8'(xs()));
      host.xact(7'h50, 8'h20 + 8'(i), 1'b0, q_m[i], d, nak);
      chk({7'h0, nak}, 8'h00);
    end
    for (int i = 0; i < 4; i++)
    begin
      host.xact(7'h50, 8'h20 + 8'(i), 1'b1, 8'h00, d, nak);
      chk(d, q_m.pop_front());
      chk({7'h0, nak}, 8'h00);
    end
    // eight bytes from mid-page must wrap to the start of that page
    for (int i = 0; i < 8; i++)
    begin
      q_m.push_back(8'(xs()));
      w[8*i +: 8] = q_m[i];
    end
    host.burst(7'h50, 8'h34, w, nak);
    chk({7'h0, nak}, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      host.xact(7'h50, 8'h30 + 8'(i), 1'b1, 8'h00, d, nak);
      chk(d, q_m[(i + 4) % 8]);
    end
    $display("test memory done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
